// ### inc/stseq_pkg.sv
package stseq_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int MS_CNT_W = 9;
    localparam int CYC_CNT_W = 17;

    // Sequence times in milliseconds
    localparam logic [7:0] MIN_DELAY_MS = 8'h02;
    localparam logic [7:0] LOAD_MIN_MS = 8'h05;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_VOUT = 8'h04;
    localparam logic [7:0] REG_DELAY = 8'h08;
    localparam logic [7:0] REG_RAMP = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Field positions
    localparam int CTRL_RELOAD_BIT = 0;
    localparam int STATUS_READY_BIT = 4;
    localparam int VOUT_W = 13;

    // Output level limits and reset values, millivolts and ms
    localparam logic [12:0] VOUT_MIN_MV = 13'h0258;
    localparam logic [12:0] VOUT_MAX_MV = 13'h1388;
    localparam logic [12:0] VOUT_RST_MV = 13'h0258;
    localparam logic [7:0] DELAY_RST_MS = 8'h02;
    localparam logic [7:0] RAMP_RST_MS = 8'h02;

    // Strap classes
    localparam logic [1:0] CLS_LOW = 2'h0;
    localparam logic [1:0] CLS_OPEN = 2'h1;
    localparam logic [1:0] CLS_HIGH = 2'h2;
    localparam logic [1:0] CLS_RES = 2'h3;

    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_MEM_LOAD,
        ST_STRAP_LOAD,
        ST_READY,
        ST_DELAY,
        ST_RAMP,
        ST_ON
    } stseq_state_t;

    typedef struct packed {
        logic [1:0] cls;
        logic [4:0] res_idx;
    } stseq_strap_t;

    typedef struct packed {
        logic [12:0] vout_mv;
        logic [7:0] delay_ms;
        logic [7:0] ramp_ms;
    } stseq_cfg_t;

endpackage : stseq_pkg

// ### rtl/stseq_strap_decode.sv
module stseq_strap_decode (
    // Straps
    input wire stseq_pkg::stseq_strap_t output_level_strap_pin,
    input wire stseq_pkg::stseq_strap_t ss_strap,
    // Decoded settings
    output stseq_pkg::stseq_cfg_t strap_cfg
);

    // Resistor index to millivolts
    function automatic logic [12:0] res_to_mv(input logic [4:0] idx);
        logic [12:0] mv;
        mv = 13'h0000;
        case (idx)
            5'h00: mv = 13'h0258;
            5'h01: mv = 13'h02bc;
            5'h02: mv = 13'h02ee;
            5'h03: mv = 13'h0320;
            5'h04: mv = 13'h0384;
            5'h05, 5'h06, 5'h07:
                mv = 13'h03e8 + 13'(({8'h00, idx} - 13'h0005) * 13'h0064);
            5'h08: mv = 13'h04e2;
            5'h1e: mv = 13'h1388;
            5'h1f: mv = 13'h1388;
            default:
                mv = 13'h0514 + 13'(({8'h00, idx} - 13'h0009) * 13'h0064);
        endcase
        return mv;
    endfunction : res_to_mv

    // Three-level strap time, in ms
    function automatic logic [7:0] pin_ms(input logic [1:0] cls);
        logic [7:0] ms;
        ms = 8'h05;
        case (cls)
            stseq_pkg::CLS_LOW: ms = 8'h02;
            stseq_pkg::CLS_HIGH: ms = 8'h0a;
            default: ms = 8'h05;
        endcase
        return ms;
    endfunction : pin_ms

    // Cyclic 5/10/20 ms pattern in time tables
    function automatic logic [7:0] cyc_ms(input logic [4:0] sel);
        logic [7:0] ms;
        ms = 8'h05;
        case (sel % 5'h03)
            5'h01: ms = 8'h0a;
            5'h02: ms = 8'h14;
            default: ms = 8'h05;
        endcase
        return ms;
    endfunction : cyc_ms

    wire [4:0] ss_idx = (ss_strap.res_idx > 5'h1d) ? 5'h1d : ss_strap.res_idx;
    wire [4:0] ss_grp = ss_idx / 5'h03;
    wire output_level_strap_pin_res = output_level_strap_pin.cls == stseq_pkg::CLS_RES;
    wire ss_res = ss_strap.cls == stseq_pkg::CLS_RES;
    wire [12:0] output_level_strap_pin_pin_mv =
        (output_level_strap_pin.cls == stseq_pkg::CLS_LOW) ? 13'h04b0 :
        (output_level_strap_pin.cls == stseq_pkg::CLS_OPEN) ? 13'h05dc :
        13'h0ce4;
    // Ramp column repeats 5,10,2 then 5,10,20,2 then 5,10,20
    wire [7:0] ss_res_ramp =
        (ss_grp == 5'h02 || ss_grp == 5'h06) ? 8'h02 :
        (ss_grp == 5'h05 || ss_grp == 5'h09) ? 8'h14 :
        cyc_ms(ss_grp > 5'h05 ? ss_grp - 5'h01 : ss_grp);

    assign strap_cfg.vout_mv = output_level_strap_pin_res ?
        res_to_mv(output_level_strap_pin.res_idx) : output_level_strap_pin_pin_mv;
    assign strap_cfg.delay_ms = ss_res ? cyc_ms(ss_idx) :
        pin_ms(ss_strap.cls);
    assign strap_cfg.ramp_ms = ss_res ? ss_res_ramp :
        pin_ms(ss_strap.cls);

endmodule : stseq_strap_decode

// ### rtl/stseq_top.sv
// The register addresses and the APB register port are this design's own decisions.
module stseq_top #(
    parameter int CYC_PER_MS = stseq_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Enable pin
    input wire logic en,
    // Non-volatile memory port
    output logic nvm_req,
    input wire logic nvm_ack,
    input wire logic nvm_valid,
    input wire stseq_pkg::stseq_cfg_t nvm_cfg,
    // Strap pins, already classified
    input wire stseq_pkg::stseq_strap_t output_level_strap_pin,
    input wire stseq_pkg::stseq_strap_t ss_strap,
    // Sequencer outputs
    output logic seq_ready,
    output logic ramp_en,
    output logic out_on,
    output logic [7:0] ramp_ms,
    output logic [12:0] vout_mv
);

    function automatic logic is_loading(input stseq_pkg::stseq_state_t s);
        return s == stseq_pkg::ST_POWER_UP || s == stseq_pkg::ST_MEM_LOAD ||
            s == stseq_pkg::ST_STRAP_LOAD;
    endfunction : is_loading

    function automatic logic vout_ok(input logic [31:0] d);
        return d[31:13] == 19'h00000 && d[12:0] >= stseq_pkg::VOUT_MIN_MV &&
            d[12:0] <= stseq_pkg::VOUT_MAX_MV;
    endfunction : vout_ok

    localparam logic [16:0] TICK_LAST = 17'(CYC_PER_MS - 1);

    stseq_pkg::stseq_state_t state;
    stseq_pkg::stseq_state_t next_state;
    stseq_pkg::stseq_cfg_t cfg;
    stseq_pkg::stseq_cfg_t next_cfg;
    stseq_pkg::stseq_cfg_t strap_cfg;
    logic [16:0] cyc_cnt;
    logic [8:0] ms_cnt;
    logic strap_take;

    stseq_strap_decode u_decode (
        .output_level_strap_pin(output_level_strap_pin),
        .ss_strap(ss_strap),
        .strap_cfg(strap_cfg)
    );

    // Bus decode
    wire busy = is_loading(state);
    wire access = psel & penable & ~pready;
    wire fire = psel & penable & pready;
    wire sel_ctrl = paddr == stseq_pkg::REG_CTRL;
    wire sel_vout = paddr == stseq_pkg::REG_VOUT;
    wire sel_delay = paddr == stseq_pkg::REG_DELAY;
    wire sel_ramp = paddr == stseq_pkg::REG_RAMP;
    wire sel_status = paddr == stseq_pkg::REG_STATUS;
    wire mapped = sel_ctrl | sel_vout | sel_delay | sel_ramp | sel_status;
    wire bad_vout = pwrite & sel_vout & ~vout_ok(pwdata);
    wire acc_err = busy | ~mapped | bad_vout;
    wire wr_ok = fire & pwrite & ~pslverr;
    wire reload = wr_ok & sel_ctrl & pwdata[stseq_pkg::CTRL_RELOAD_BIT];
    wire [31:0] status_word = {27'h0000000, ~busy, 1'b0, 3'(state)};
    wire [31:0] rd_word =
        sel_vout ? {19'h00000, cfg.vout_mv} :
        sel_delay ? {24'h000000, cfg.delay_ms} :
        sel_ramp ? {24'h000000, cfg.ramp_ms} :
        sel_status ? status_word : 32'h00000000;

    // Timer
    wire tick = cyc_cnt == TICK_LAST;
    wire timer_clr = next_state != state;
    wire [7:0] eff_delay = (cfg.delay_ms < stseq_pkg::MIN_DELAY_MS) ?
        stseq_pkg::MIN_DELAY_MS : cfg.delay_ms;
    wire delay_done = ms_cnt >= {1'b0, eff_delay};
    wire ramp_done = ms_cnt >= {1'b0, cfg.ramp_ms};
    wire load_done = ms_cnt >= {1'b0, stseq_pkg::LOAD_MIN_MS};

    always_comb begin
        next_state = state;
        case (state)
            stseq_pkg::ST_POWER_UP: next_state = stseq_pkg::ST_MEM_LOAD;
            stseq_pkg::ST_MEM_LOAD: begin
                if (nvm_ack) begin
                    next_state = stseq_pkg::ST_STRAP_LOAD;
                end
            end
            stseq_pkg::ST_STRAP_LOAD: begin
                if (load_done) begin
                    next_state = stseq_pkg::ST_READY;
                end
            end
            stseq_pkg::ST_READY: begin
                if (en) begin
                    next_state = stseq_pkg::ST_DELAY;
                end
            end
            stseq_pkg::ST_DELAY: begin
                if (!en) begin
                    next_state = stseq_pkg::ST_READY;
                end else if (delay_done) begin
                    next_state = stseq_pkg::ST_RAMP;
                end
            end
            stseq_pkg::ST_RAMP: begin
                if (!en) begin
                    next_state = stseq_pkg::ST_READY;
                end else if (ramp_done) begin
                    next_state = stseq_pkg::ST_ON;
                end
            end
            stseq_pkg::ST_ON: begin
                if (!en) begin
                    next_state = stseq_pkg::ST_READY;
                end
            end
            default: next_state = stseq_pkg::ST_POWER_UP;
        endcase
        if (reload) begin
            next_state = stseq_pkg::ST_MEM_LOAD;
        end
    end

    // Memory values win; straps fill only when memory holds none
    always_comb begin
        next_cfg = cfg;
        if (state == stseq_pkg::ST_MEM_LOAD && nvm_ack && nvm_valid) begin
            next_cfg = nvm_cfg;
        end else if (strap_take) begin
            next_cfg = strap_cfg;
        end else if (wr_ok && sel_vout) begin
            next_cfg.vout_mv = pwdata[12:0];
        end else if (wr_ok && sel_delay) begin
            next_cfg.delay_ms = pwdata[7:0];
        end else if (wr_ok && sel_ramp) begin
            next_cfg.ramp_ms = pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= stseq_pkg::ST_POWER_UP;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg <= '{stseq_pkg::VOUT_RST_MV, stseq_pkg::DELAY_RST_MS,
                stseq_pkg::RAMP_RST_MS};
            strap_take <= 1'b0;
        end else begin
            cfg <= next_cfg;
            // Memory data flag is gone by the next cycle, so keep it here
            strap_take <= state == stseq_pkg::ST_MEM_LOAD && nvm_ack &&
                !nvm_valid;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_cnt <= 17'h00000;
            ms_cnt <= 9'h000;
        end else if (timer_clr) begin
            cyc_cnt <= 17'h00000;
            ms_cnt <= 9'h000;
        end else if (tick) begin
            cyc_cnt <= 17'h00000;
            ms_cnt <= (ms_cnt == 9'h1ff) ? ms_cnt : ms_cnt + 9'h001;
        end else begin
            cyc_cnt <= cyc_cnt + 17'h00001;
        end
    end

    // One wait state: pready rises the cycle after the access phase opens
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= access;
            pslverr <= access & acc_err;
            prdata <= (access && !pwrite && !acc_err) ? rd_word : 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvm_req <= 1'b0;
            seq_ready <= 1'b0;
            ramp_en <= 1'b0;
            out_on <= 1'b0;
            ramp_ms <= 8'h00;
            vout_mv <= 13'h0000;
        end else begin
            nvm_req <= next_state == stseq_pkg::ST_MEM_LOAD;
            seq_ready <= !is_loading(next_state);
            ramp_en <= next_state == stseq_pkg::ST_RAMP;
            out_on <= next_state == stseq_pkg::ST_RAMP ||
                next_state == stseq_pkg::ST_ON;
            ramp_ms <= next_cfg.ramp_ms;
            vout_mv <= next_cfg.vout_mv;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_powered;
        state == stseq_pkg::ST_POWER_UP && rst_b;
    endsequence

    sequence s_mem_then_req;
        state == stseq_pkg::ST_MEM_LOAD ##0 nvm_req;
    endsequence

    sequence s_mem_ack;
        state == stseq_pkg::ST_MEM_LOAD && nvm_ack && !reload;
    endsequence

    a_nvm_first: assert property (
        s_powered |=> s_mem_then_req)
        else $error("memory request missing after power-up");

    a_strap_after_mem: assert property (
        s_mem_ack |=> state == stseq_pkg::ST_STRAP_LOAD ##1 strap_take == 1'b0)
        else $error("strap load did not follow memory step");

    a_reload_restart: assert property (
        reload |=> state == stseq_pkg::ST_MEM_LOAD ##0 nvm_req)
        else $error("reload did not restart memory load");

    a_enable_ignored: assert property (
        is_loading(state) |=> state != stseq_pkg::ST_DELAY)
        else $error("enable acted on during load");

    a_bus_ignored: assert property (
        (busy && fire && pwrite && !nvm_ack && !strap_take)
        |-> pslverr ##1 $stable(cfg))
        else $error("bus write took effect during load");

    a_ready_after_load: assert property (
        (state == stseq_pkg::ST_STRAP_LOAD && load_done && !reload)
        |=> state == stseq_pkg::ST_READY ##1 seq_ready)
        else $error("not ready after loading");

    a_min_delay: assert property (
        (state == stseq_pkg::ST_DELAY &&
            ms_cnt < {1'b0, stseq_pkg::MIN_DELAY_MS})
        |=> state != stseq_pkg::ST_RAMP)
        else $error("ramp before minimum delay");

    a_full_delay: assert property (
        (state == stseq_pkg::ST_DELAY && ms_cnt < {1'b0, cfg.delay_ms})
        |=> state != stseq_pkg::ST_RAMP)
        else $error("ramp before configured delay");

    a_ramp_starts: assert property (
        $rose(state == stseq_pkg::ST_RAMP) |-> ramp_en && out_on)
        else $error("ramp outputs did not follow delay end");

    a_delay_timing: assert property (
        (state == stseq_pkg::ST_READY && en && !reload)
        |=> state == stseq_pkg::ST_DELAY && ms_cnt == 9'h000 &&
            cyc_cnt == 17'h00000)
        else $error("delay timing did not start on enable");

    a_vout_range: assert property (
        !is_loading(state) |-> cfg.vout_mv >= stseq_pkg::VOUT_MIN_MV &&
            cfg.vout_mv <= stseq_pkg::VOUT_MAX_MV)
        else $error("target level outside range");

endmodule : stseq_top

// ### dv/stseq_nvm_model.sv
module stseq_nvm_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request from the sequencer
    input wire logic nvm_req,
    // Bench control of the stored image
    input wire logic has_data,
    input wire logic [3:0] lat,
    input wire stseq_pkg::stseq_cfg_t stored,
    // Answer
    output logic nvm_ack,
    output logic nvm_valid,
    output stseq_pkg::stseq_cfg_t nvm_cfg
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt;
    logic done;

    // Data lines churn outside the answer cycle so stale values never match
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            done <= 1'b0;
            nvm_ack <= 1'b0;
            nvm_valid <= 1'b0;
            nvm_cfg <= '0;
        end else begin
            nvm_ack <= 1'b0;
            nvm_valid <= 1'b0;
            nvm_cfg <= ~nvm_cfg;
            if (!nvm_req) begin
                cnt <= 4'h0;
                done <= 1'b0;
            end else if (!done && cnt == lat) begin
                nvm_ack <= 1'b1;
                nvm_valid <= has_data;
                nvm_cfg <= stored;
                done <= 1'b1;
            end else if (!done) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule : stseq_nvm_model

// ### dv/test_startup_sequencer.sv
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module test_startup_sequencer;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CPM = 10;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, en;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic nvm_req, nvm_ack, nvm_valid, has_data;
    logic seq_ready, ramp_en, out_on;
    logic [7:0] ramp_ms;
    logic [12:0] vout_mv;
    logic [3:0] lat;
    stseq_pkg::stseq_cfg_t nvm_cfg, stored;
    stseq_pkg::stseq_strap_t output_level_strap_pin, ss_strap;
    int num_errors = 0;
    int checked = 0;

    stseq_top #(.CYC_PER_MS(CPM)) u_dut (.clk(clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .en(en), .nvm_req(nvm_req), .nvm_ack(nvm_ack),
        .nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg),
        .output_level_strap_pin(output_level_strap_pin),
        .ss_strap(ss_strap), .seq_ready(seq_ready), .ramp_en(ramp_en),
        .out_on(out_on), .ramp_ms(ramp_ms), .vout_mv(vout_mv));

    stseq_nvm_model u_nvm (.clk(clk), .rst_b(rst_b), .nvm_req(nvm_req),
        .has_data(has_data), .lat(lat), .stored(stored),
        .nvm_ack(nvm_ack), .nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg));

    task automatic complete_run;
        if (num_errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run

    task automatic timed_out(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            complete_run();
        end
    endtask : timed_out

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        timed_out(n, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clk);
    endtask : apb

    // Waits for ready; the output must not ramp while loading
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
            `CHK("ramp_early", 1'b0, ramp_en);
        end while (seq_ready !== 1'b1 && n < 500);
        timed_out(n, 500);
    endtask : wait_ready

    task automatic reload(output int n);
        logic [31:0] rd;
        logic err;
        apb(1'b1, stseq_pkg::REG_CTRL, 32'h1, rd, err);
        wait_ready(n);
        `CHK("load_len", 1'b1, n > 5 * CPM);
    endtask : reload

    task automatic sc_boot;
        logic [31:0] rd;
        logic err;
        int n;
        repeat (2) @(posedge clk);
        `CHK("nvm_req", 1'b1, nvm_req);
        apb(1'b0, stseq_pkg::REG_STATUS, 32'h0, rd, err);
        `CHK("load_refuse", 1'b1, err);
        apb(1'b1, stseq_pkg::REG_VOUT, 32'h0ce4, rd, err);
        `CHK("load_wr_refuse", 1'b1, err);
        wait_ready(n);
        `CHK("load_wr_vout", 13'h04b0, vout_mv);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ramp_en !== 1'b1 && n < 100);
        `CHK("tied_en_ramp", 1'b1, n < 100);
        en <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, stseq_pkg::REG_STATUS, 32'h0, rd, err);
        `CHK("status", 32'h13, rd);
    endtask : sc_boot

    task automatic sc_straps;
        logic [6:0] vs [5] = '{7'h00, 7'h20, 7'h40, 7'h60, 7'h7e};
        logic [6:0] ss [5] = '{7'h00, 7'h20, 7'h40, 7'h62, 7'h67};
        logic [12:0] ve [5] = '{13'h04b0, 13'h05dc, 13'h0ce4, 13'h0258,
                                13'h1388};
        logic [7:0] re [5] = '{8'h02, 8'h05, 8'h0a, 8'h05, 8'h02};
        logic [7:0] de [5] = '{8'h02, 8'h05, 8'h0a, 8'h14, 8'h0a};
        logic [31:0] rd;
        logic err;
        int n;
        for (int i = 0; i < 5; i++) begin
            output_level_strap_pin <= vs[i];
            ss_strap <= ss[i];
            reload(n);
            apb(1'b0, stseq_pkg::REG_DELAY, 32'h0, rd, err);
            `CHK("delay_reg", {24'h0, de[i]}, rd);
            `CHK("vout_mv", ve[i], vout_mv);
            `CHK("ramp_ms", re[i], ramp_ms);
        end
    endtask : sc_straps

    task automatic sc_vout;
        logic [31:0] wd [4] = '{32'h0258, 32'h1389, 32'h1388, 32'h0257};
        logic ee [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        logic [12:0] ve [4] = '{13'h0258, 13'h0258, 13'h1388, 13'h1388};
        logic [31:0] rd;
        logic err;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, stseq_pkg::REG_VOUT, wd[i], rd, err);
            `CHK("vout_err", ee[i], err);
            apb(1'b0, stseq_pkg::REG_VOUT, 32'h0, rd, err);
            `CHK("vout_reg", {19'h0, ve[i]}, rd);
            `CHK("vout_mv", ve[i], vout_mv);
        end
        apb(1'b0, 8'h14, 32'h0, rd, err);
        `CHK("unmapped", 1'b1, err);
    endtask : sc_vout

    task automatic sc_delay;
        logic [7:0] dly [4] = '{8'h00, 8'h01, 8'h03, 8'h14};
        int eff [4] = '{2, 2, 3, 20};
        logic [31:0] rd;
        logic err;
        int n;
        apb(1'b1, stseq_pkg::REG_RAMP, 32'h1, rd, err);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, stseq_pkg::REG_DELAY, {24'h0, dly[i]}, rd, err);
            en <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ramp_en !== 1'b1 && n < 400);
            timed_out(n, 400);
            `CHK("delay_len", eff[i] * CPM + 3, n);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (ramp_en === 1'b1 && n < 400);
            `CHK("ramp_len", CPM + 1, n);
            `CHK("out_on", 1'b1, out_on);
            en <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK("out_off", 1'b0, out_on);
        end
    endtask : sc_delay

    task automatic sc_reload;
        logic [31:0] rd;
        logic err;
        int n;
        has_data <= 1'b1;
        stored <= {13'h0ce4, 8'h03, 8'h01};
        en <= 1'b1;
        apb(1'b1, stseq_pkg::REG_CTRL, 32'h1, rd, err);
        repeat (2) @(posedge clk);
        `CHK("reload_req", 1'b1, nvm_req);
        `CHK("reload_ready", 1'b0, seq_ready);
        wait_ready(n);
        `CHK("nvm_vout", 13'h0ce4, vout_mv);
        `CHK("nvm_ramp", 8'h01, ramp_ms);
        en <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, stseq_pkg::REG_STATUS, 32'h0, rd, err);
        `CHK("status", 32'h13, rd);
    endtask : sc_reload

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        en = 1'b1;
        has_data = 1'b0;
        lat = 4'h3;
        stored = '0;
        output_level_strap_pin = '0;
        ss_strap = '0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        sc_boot();
        sc_straps();
        sc_vout();
        sc_delay();
        sc_reload();
        complete_run();
    end
endmodule : test_startup_sequencer
